// *** hw/gpp_defines.vh ***
`ifndef GPP_DEFINES_VH
`define GPP_DEFINES_VH
// Register addresses in the special-function space
`define GPP_ADDR_P1_LATCH   8'h90
`define GPP_ADDR_P1_INSEL   8'hAD
`define GPP_ADDR_P1_DRIVE   8'hA5
`define GPP_ADDR_P2_LATCH   8'hA0
`define GPP_ADDR_P2_DRIVE   8'hA6
// Reset values
`define GPP_RST_LATCH       8'hFF
`define GPP_RST_DRIVE       8'h00
`define GPP_RST_INSEL       8'hFF
`endif

// *** hw/gpp_pin_slice.v ***
`timescale 1ns/10ps
`default_nettype none
// One port pin: owner selection and driver mode
module gpp_pin_slice (
  input  wire latch_bit,
  input  wire push_pull,
  input  wire force_od,
  input  wire alt_own,
  input  wire alt_out,
  output wire pin_o,
  output wire pin_oe
);
  wire level;
  wire pp;
  assign level  = alt_own ? alt_out : latch_bit;
  assign pp     = push_pull & ~force_od;
  // Low always driven; high driven only in push-pull
  assign pin_o  = level;
  assign pin_oe = ~level | pp;
endmodule
`default_nettype wire

// *** hw/gpp_ports12.v ***
// Behaviour
// - Port-1 latch bit drives pin low for 0, high for 1.
// - High is driven only in push-pull; open-drain leaves pin open.
// - Plain port data reads return the pin levels; read-modify-write reads return the latch.
// - Analog port-1 pins skip crossbar and lose their digital input.
// - Analog port-1 pins still drive per latch and drive-select, except while the non-multiplexed memory bus owns port 1.
// - Non-multiplexed memory bus drives address 15:8 on port 1.
// - Drive-select bit 0 is open-drain, 1 is push-pull.
// - Two-wire and mode-0 receiver pins are forced open-drain.
// - Port 2 behaves like port 1, except that it has no input select and no analog mode.
// - Memory bus drives port 2: address 15:8 muxed, 7:0 non-muxed.
`timescale 1ns/10ps
`default_nettype none
`include "gpp_defines.vh"
module gpp_ports12 (
  input  wire        clk,
  input  wire        rstn,
  // Register bus
  input  wire [7:0]  sfr_addr,
  input  wire        sfr_wr,
  input  wire [7:0]  sfr_wdata,
  input  wire        sfr_rd,
  input  wire        sfr_rmw,
  output reg  [7:0]  sfr_rdata,
  // Crossbar, port 1
  input  wire [7:0]  xbar1_own,
  input  wire [7:0]  xbar1_out,
  input  wire [7:0]  xbar1_force_od,
  // Crossbar, port 2
  input  wire [7:0]  xbar2_own,
  input  wire [7:0]  xbar2_out,
  input  wire [7:0]  xbar2_force_od,
  // External memory interface
  input  wire        emif_active,
  input  wire        emif_muxed,
  input  wire [15:0] emif_addr,
  // Port 1 pins
  input  wire [7:0]  port1_pin_i,
  output wire [7:0]  port1_pin_o,
  output wire [7:0]  port1_pin_oe,
  // Port 2 pins
  input  wire [7:0]  port2_pin_i,
  output wire [7:0]  port2_pin_o,
  output wire [7:0]  port2_pin_oe,
  // Port 1 analog control
  output wire [7:0]  port1_analog,
  output wire [7:0]  port1_xbar_skip,
  output wire [7:0]  port1_digital_in
);
  reg  [7:0] port1_latch;
  reg  [7:0] port2_latch;
  reg  [7:0] port1_drive_select;
  reg  [7:0] port2_drive_select;
  reg  [7:0] port1_input_select;
  reg  [7:0] next_rdata;

  reg  [7:0] own1;
  reg  [7:0] out1;
  reg  [7:0] own2;
  reg  [7:0] out2;
  wire       emif_p1;

  wire [7:0] p1_read;
  wire [7:0] p2_read;

  wire       wr_p1_latch;
  wire       wr_p2_latch;
  wire       wr_p1_drive;
  wire       wr_p2_drive;
  wire       wr_p1_insel;

  // One write enable per register; unmapped addresses write nothing
  assign wr_p1_latch = sfr_wr & (sfr_addr == `GPP_ADDR_P1_LATCH);
  assign wr_p2_latch = sfr_wr & (sfr_addr == `GPP_ADDR_P2_LATCH);
  assign wr_p1_drive = sfr_wr & (sfr_addr == `GPP_ADDR_P1_DRIVE);
  assign wr_p2_drive = sfr_wr & (sfr_addr == `GPP_ADDR_P2_DRIVE);
  assign wr_p1_insel = sfr_wr & (sfr_addr == `GPP_ADDR_P1_INSEL);

  // Port-1 latch keeps its value while another owner drives the pin
  always @(posedge clk or negedge rstn) begin
    if (!rstn)
      port1_latch <= `GPP_RST_LATCH;
    else if (wr_p1_latch)
      port1_latch <= sfr_wdata;
  end

  // Port-2 latch
  always @(posedge clk or negedge rstn) begin
    if (!rstn)
      port2_latch <= `GPP_RST_LATCH;
    else if (wr_p2_latch)
      port2_latch <= sfr_wdata;
  end

  // Port-1 drive select
  always @(posedge clk or negedge rstn) begin
    if (!rstn)
      port1_drive_select <= `GPP_RST_DRIVE;
    else if (wr_p1_drive)
      port1_drive_select <= sfr_wdata;
  end

  // Port-2 drive select
  always @(posedge clk or negedge rstn) begin
    if (!rstn)
      port2_drive_select <= `GPP_RST_DRIVE;
    else if (wr_p2_drive)
      port2_drive_select <= sfr_wdata;
  end

  // Port-1 input select
  always @(posedge clk or negedge rstn) begin
    if (!rstn)
      port1_input_select <= `GPP_RST_INSEL;
    else if (wr_p1_insel)
      port1_input_select <= sfr_wdata;
  end

  // Input-select bit 0 puts the pin in analog mode
  assign port1_analog     = ~port1_input_select;
  assign port1_xbar_skip  = port1_analog;
  assign port1_digital_in = port1_pin_i & port1_input_select;

  // Memory bus claims port 1 only in non-multiplexed mode
  assign emif_p1 = emif_active & ~emif_muxed;

  // Analog pins keep latch-driven output unless non-muxed memory bus claims port 1; crossbar cannot claim them
  always @* begin
    if (emif_p1) begin
      own1 = 8'hFF;
      out1 = emif_addr[15:8];
    end else begin
      own1 = xbar1_own & port1_input_select;
      out1 = xbar1_out;
    end
  end

  // Memory bus claims port 2 in either mode
  always @* begin
    if (emif_active) begin
      own2 = 8'hFF;
      if (emif_muxed)
        out2 = emif_addr[15:8];
      else
        out2 = emif_addr[7:0];
    end else begin
      own2 = xbar2_own;
      out2 = xbar2_out;
    end
  end

  genvar i;
  genvar k;

  // Port-1 pin drivers
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_pin1
      gpp_pin_slice u_p1 (
        .latch_bit (port1_latch[i]),
        .push_pull (port1_drive_select[i]),
        .force_od  (xbar1_force_od[i]),
        .alt_own   (own1[i]),
        .alt_out   (out1[i]),
        .pin_o     (port1_pin_o[i]),
        .pin_oe    (port1_pin_oe[i])
      );
    end
  endgenerate

  // Port-2 pin drivers
  generate
    for (k = 0; k < 8; k = k + 1) begin : g_pin2
      gpp_pin_slice u_p2 (
        .latch_bit (port2_latch[k]),
        .push_pull (port2_drive_select[k]),
        .force_od  (xbar2_force_od[k]),
        .alt_own   (own2[k]),
        .alt_out   (out2[k]),
        .pin_o     (port2_pin_o[k]),
        .pin_oe    (port2_pin_oe[k])
      );
    end
  endgenerate

  // Plain reads see pins; read-modify-write reads see the latch
  assign p1_read = sfr_rmw ? port1_latch : port1_pin_i;
  assign p2_read = sfr_rmw ? port2_latch : port2_pin_i;

  always @* begin
    next_rdata = 8'h00;
    case (sfr_addr)
      `GPP_ADDR_P1_LATCH: next_rdata = p1_read;
      `GPP_ADDR_P2_LATCH: next_rdata = p2_read;
      `GPP_ADDR_P1_DRIVE: next_rdata = port1_drive_select;
      `GPP_ADDR_P2_DRIVE: next_rdata = port2_drive_select;
      `GPP_ADDR_P1_INSEL: next_rdata = port1_input_select;
      default:            next_rdata = 8'h00;
    endcase
  end

  // Read data holds until the next read strobe

  always @(posedge clk or negedge rstn) begin
    if (!rstn)
      sfr_rdata <= 8'h00;
    else if (sfr_rd)
      sfr_rdata <= next_rdata;
  end
endmodule
`default_nettype wire

// *** tb/gpp_board.sv ***
`timescale 1ns/10ps
`default_nettype none
// Board pins with pull-ups; ext_low is another part pulling a pin low
module gpp_board (
  input  wire logic [7:0] o,
  input  wire logic [7:0] oe,
  input  wire logic [7:0] ext_low,
  output logic [7:0]      pin
);
  assign pin = (o | ~oe) & ~ext_low;
endmodule
`default_nettype wire

// *** tb/gpp_chk.sv ***
`timescale 1ns/10ps
`default_nettype none
module gpp_chk (
  input wire logic        clk, rstn, sfr_rd, sfr_rmw, emif_active, emif_muxed,
  input wire logic [7:0]  sfr_addr, sfr_rdata, port1_pin_i, port1_pin_o,
  input wire logic [7:0]  port1_pin_oe, port1_analog, port1_xbar_skip,
  input wire logic [7:0]  port1_digital_in, xbar1_force_od, port2_pin_o,
  input wire logic [15:0] emif_addr
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_low; (~port1_pin_o & ~port1_pin_oe) == 8'h00; endproperty
  a_low: assert property (p_low) else $error("low undriven");
  property p_od; (port1_pin_oe & port1_pin_o & xbar1_force_od) == 8'h00;
  endproperty
  a_od: assert property (p_od) else $error("forced pin high");
  property p_skip; port1_xbar_skip == port1_analog; endproperty
  a_skip: assert property (p_skip) else $error("skip mask");
  property p_din; port1_digital_in == (port1_pin_i & ~port1_analog);
  endproperty
  a_din: assert property (p_din) else $error("digital in");
  property p_e1; emif_active && !emif_muxed |-> port1_pin_o == emif_addr[15:8];
  endproperty
  a_e1: assert property (p_e1) else $error("port1 address");
  property p_e2m; emif_active && emif_muxed |-> port2_pin_o == emif_addr[15:8];
  endproperty
  a_e2m: assert property (p_e2m) else $error("port2 high address");
  property p_e2n; emif_active && !emif_muxed |-> port2_pin_o == emif_addr[7:0];
  endproperty
  a_e2n: assert property (p_e2n) else $error("port2 low address");
  property p_rd; sfr_rd && !sfr_rmw && sfr_addr == 8'h90
    |=> sfr_rdata == $past(port1_pin_i); endproperty
  a_rd: assert property (p_rd) else $error("pin read");
endmodule
bind gpp_ports12 gpp_chk i_gpp_chk (.clk, .rstn, .sfr_rd, .sfr_rmw,
  .emif_active, .emif_muxed, .sfr_addr, .sfr_rdata, .port1_pin_i, .port1_pin_o,
  .port1_pin_oe, .port1_analog, .port1_xbar_skip, .port1_digital_in,
  .xbar1_force_od, .port2_pin_o, .emif_addr);
`default_nettype wire

// *** tb/test_port1_port2_gpio_latches.sv ***
`timescale 1ns/10ps
`default_nettype none
module test_port1_port2_gpio_latches;
  logic clk = 0, rstn = 0, wr = 0, rd = 0, rmw = 0, eon = 0, em = 0;
  logic [7:0] a = 0, wd = 0, x1 = 0, xo = 0, xf = 0, lo = 0, v, m, lf = 8'h58;
  logic [7:0] q, p1i, p1o, p1e, p2i, p2o, p2e, an, di;
  logic [15:0] ea = 0;
  int error_cnt = 0, comparisons = 0;
  gpp_ports12 i_gpp_ports12 (.clk, .rstn, .sfr_addr(a), .sfr_wr(wr),
    .sfr_wdata(wd), .sfr_rd(rd), .sfr_rmw(rmw), .sfr_rdata(q), .xbar1_own(x1),
    .xbar1_out(xo), .xbar1_force_od(xf), .xbar2_own(x1), .xbar2_out(xo),
    .xbar2_force_od(xf), .emif_active(eon), .emif_muxed(em), .emif_addr(ea),
    .port1_pin_i(p1i), .port1_pin_o(p1o), .port1_pin_oe(p1e), .port2_pin_i(p2i),
    .port2_pin_o(p2o), .port2_pin_oe(p2e), .port1_analog(an),
    .port1_xbar_skip(), .port1_digital_in(di));
  gpp_board i_gpp_board_1 (.o(p1o), .oe(p1e), .ext_low(lo), .pin(p1i));
  gpp_board i_gpp_board_2 (.o(p2o), .oe(p2e), .ext_low(lo), .pin(p2i));
  initial forever #2.5 clk = ~clk;
  function automatic logic [7:0] rnd();
    lf = {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
    return lf;
  endfunction
  task automatic chk(string n, logic [7:0] e, logic [7:0] s);
    comparisons++;
    if (s !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  // Write when w, else read; d[0] marks a read-modify-write read
  task automatic acc(logic w, logic [7:0] ad, logic [7:0] d);
    @(posedge clk);
    wr <= w; rd <= !w; rmw <= !w && d[0]; a <= ad; wd <= d;
    @(posedge clk);
    wr <= 0; rd <= 0; rmw <= 0;
    @(negedge clk);
  endtask
  task automatic finish_test();
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #20000;
    error_cnt++;
    finish_test();
  end
  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1;
    acc(0, 8'hA0, 1); chk("p2 latch reset", 8'hFF, q);
    chk("oe reset", 8'h00, p1e);
    for (int i = 0; i < 12; i++) begin
      v = rnd(); m = rnd();
      @(posedge clk); x1 <= 0; xf <= rnd(); lo <= rnd();
      acc(1, 8'hA5, m); acc(1, 8'h90, v); acc(1, 8'hA6, m); acc(1, 8'hA0, v);
      chk("p1 out", v, p1o);
      chk("p1 oe", ~v | m & ~xf, p1e);
      chk("p2 oe", ~v | m & ~xf, p2e);
      acc(0, 8'h90, 0); chk("p1 read", v & ~lo, q);
      acc(0, 8'h33, 0); chk("unmapped", 8'h00, q);
      acc(1, 8'hAD, m);
      @(posedge clk); x1 <= rnd(); xo <= rnd();
      @(negedge clk); chk("analog", ~m, an);
      chk("digital in", p1i & m, di);
      chk("owned", x1 & m & xo | ~(x1 & m) & v, p1o);
      chk("p2 owned", x1 & xo | ~x1 & v, p2o);
      @(posedge clk); eon <= 1; em <= i[0]; ea <= {rnd(), rnd()};
      @(negedge clk); if (!em) chk("emif p1", ea[15:8], p1o);
      chk("emif p2", em ? ea[15:8] : ea[7:0], p2o);
      @(posedge clk); eon <= 0;
      acc(0, 8'h90, 1); chk("latch kept", v, q);
      $display("test %0d done", i);
    end
    finish_test();
  end
endmodule
`default_nettype wire
